//--- hdl/afc_regs.v
// Behaviour
// R01 - filter order bits 6:5, 00 sinc5+sinc1, 11 sinc3
// R02 - rate code bits 4:0 selects output rate
// R03 - filter words setups 1-3, reset 0x0500
// R04 - zero-scale coefficient 24 bits, reset 0x800000
// R05 - zero-scale at 0x30 applies to setup 0
// R06 - zero-scale setups 1-3 at 0x31-0x33
// R07 - full-scale coefficient reset 0x5xxxx0; full_scale_coeff_r output resets to 0x000000
// R08 - full-scale at 0x38 applies to setup 0
// R09 - full-scale setups 1-3 at 0x39-0x3b
// R10 - filter word write restarts conversion sequence
// R11 - postfilter needs filter order 00
// R12 - direct map uses bits 14:0 as decimation
// R13 - codes 01, 10 fall back to default
`timescale 1ns/1ns
`default_nettype none
`include "afc_consts.vh"

module afc_regs #(
	parameter [15:0] FULL_MID0 = 16'h0000,
	parameter [15:0] FULL_MID1 = 16'h0000,
	parameter [15:0] FULL_MID2 = 16'h0000,
	parameter [15:0] FULL_MID3 = 16'h0000
) (
	input wire sys_clk,
	input wire reset,
	input wire reg_wr,
	input wire reg_rd,
	input wire [5:0] reg_addr,
	input wire [23:0] reg_wdata,
	input wire [1:0] conv_setup,
	output reg [23:0] reg_rdata_r,
	output reg reg_rvalid_r,
	output reg reg_hit_r,
	output reg conv_restart_r,
	output reg [1:0] filter_order_sel_r,
	output reg [4:0] output_rate_code_r,
	output reg postfilter_enable_r,
	output reg [2:0] postfilter_select_r,
	output reg direct_decimation_map_r,
	output reg [14:0] decimation_value_r,
	output reg [23:0] zero_scale_coeff_r,
	output reg [23:0] full_scale_coeff_r
);
	// ****************************************
	// address decode
	// ****************************************
	wire [3:0] filt_we;
	wire [3:0] zero_we;
	wire [3:0] full_we;
	wire [15:0] filt_q [0:3];
	wire [23:0] zero_q [0:3];
	wire [23:0] full_q [0:3];
	wire [1:0] ord_q [0:3];
	wire [4:0] rate_q [0:3];
	wire [3:0] pfen_q;
	wire [2:0] pfsel_q [0:3];
	wire [3:0] map_q;
	wire [14:0] dec_q [0:3];
	wire [1:0] idx;
	wire is_filt;
	wire is_zero;
	wire is_full;
	reg [23:0] rdata_nxt;
	reg [1:0] filter_order_sel_nxt;
	reg [4:0] output_rate_code_nxt;
	reg postfilter_enable_nxt;
	reg [2:0] postfilter_select_nxt;
	reg direct_decimation_map_nxt;
	reg [14:0] decimation_value_nxt;
	reg [23:0] zero_scale_coeff_nxt;
	reg [23:0] full_scale_coeff_nxt;

	assign idx = reg_addr[1:0];
	assign is_filt = (reg_addr >= `AFC_ADDR_FILT0) && (reg_addr <= `AFC_ADDR_FILT3); // [R03]
	assign is_zero = (reg_addr >= `AFC_ADDR_ZERO0) && (reg_addr <= `AFC_ADDR_ZERO3); // [R05] [R06]
	assign is_full = (reg_addr >= `AFC_ADDR_FULL0) && (reg_addr <= `AFC_ADDR_FULL3); // [R08] [R09]

	// ****************************************
	// four setup slots
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : slot
			assign filt_we[g] = reg_wr && is_filt && (idx == g);
			assign zero_we[g] = reg_wr && is_zero && (idx == g);
			assign full_we[g] = reg_wr && is_full && (idx == g);
			afc_setup_slot #(
				.FULL_MID(g == 0 ? FULL_MID0 : g == 1 ? FULL_MID1 :
					g == 2 ? FULL_MID2 : FULL_MID3)
			) u_slot (
				.sys_clk(sys_clk),
				.reset(reset),
				.filt_we(filt_we[g]),
				.zero_we(zero_we[g]),
				.full_we(full_we[g]),
				.wr_data(reg_wdata),
				.filt_r(filt_q[g]),
				.zero_r(zero_q[g]),
				.full_r(full_q[g]),
				.eff_order_r(ord_q[g]),
				.eff_rate_r(rate_q[g]),
				.eff_pf_en_r(pfen_q[g]),
				.eff_pf_sel_r(pfsel_q[g]),
				.eff_map_r(map_q[g]),
				.eff_dec_r(dec_q[g])
			);
		end
	endgenerate

	// ****************************************
	// read mux
	// ****************************************
	always @* begin
		rdata_nxt = 24'h000000;
		case (reg_addr)
			`AFC_ADDR_FILT0: begin
				rdata_nxt = {8'h00, filt_q[0]};
			end
			`AFC_ADDR_FILT1: begin
				rdata_nxt = {8'h00, filt_q[1]}; // [R03]
			end
			`AFC_ADDR_FILT2: begin
				rdata_nxt = {8'h00, filt_q[2]}; // [R03]
			end
			`AFC_ADDR_FILT3: begin
				rdata_nxt = {8'h00, filt_q[3]}; // [R03]
			end
			`AFC_ADDR_ZERO0: begin
				rdata_nxt = zero_q[0]; // [R05]
			end
			`AFC_ADDR_ZERO1: begin
				rdata_nxt = zero_q[1]; // [R06]
			end
			`AFC_ADDR_ZERO2: begin
				rdata_nxt = zero_q[2]; // [R06]
			end
			`AFC_ADDR_ZERO3: begin
				rdata_nxt = zero_q[3]; // [R06]
			end
			`AFC_ADDR_FULL0: begin
				rdata_nxt = full_q[0]; // [R08]
			end
			`AFC_ADDR_FULL1: begin
				rdata_nxt = full_q[1]; // [R09]
			end
			`AFC_ADDR_FULL2: begin
				rdata_nxt = full_q[2]; // [R09]
			end
			`AFC_ADDR_FULL3: begin
				rdata_nxt = full_q[3]; // [R09]
			end
			default: begin
				rdata_nxt = 24'h000000;
			end
		endcase
	end

	// ****************************************
	// setup selection
	// ****************************************
	always @* begin
		filter_order_sel_nxt = ord_q[0];
		output_rate_code_nxt = rate_q[0];
		postfilter_enable_nxt = pfen_q[0];
		postfilter_select_nxt = pfsel_q[0];
		direct_decimation_map_nxt = map_q[0];
		decimation_value_nxt = dec_q[0];
		zero_scale_coeff_nxt = zero_q[0];
		full_scale_coeff_nxt = full_q[0];
		case (conv_setup)
			2'h1: begin
				filter_order_sel_nxt = ord_q[1];
				output_rate_code_nxt = rate_q[1];
				postfilter_enable_nxt = pfen_q[1];
				postfilter_select_nxt = pfsel_q[1];
				direct_decimation_map_nxt = map_q[1];
				decimation_value_nxt = dec_q[1];
				zero_scale_coeff_nxt = zero_q[1]; // [R06]
				full_scale_coeff_nxt = full_q[1]; // [R09]
			end
			2'h2: begin
				filter_order_sel_nxt = ord_q[2];
				output_rate_code_nxt = rate_q[2];
				postfilter_enable_nxt = pfen_q[2];
				postfilter_select_nxt = pfsel_q[2];
				direct_decimation_map_nxt = map_q[2];
				decimation_value_nxt = dec_q[2];
				zero_scale_coeff_nxt = zero_q[2]; // [R06]
				full_scale_coeff_nxt = full_q[2]; // [R09]
			end
			2'h3: begin
				filter_order_sel_nxt = ord_q[3];
				output_rate_code_nxt = rate_q[3];
				postfilter_enable_nxt = pfen_q[3];
				postfilter_select_nxt = pfsel_q[3];
				direct_decimation_map_nxt = map_q[3];
				decimation_value_nxt = dec_q[3];
				zero_scale_coeff_nxt = zero_q[3]; // [R06]
				full_scale_coeff_nxt = full_q[3]; // [R09]
			end
			default: begin
				filter_order_sel_nxt = ord_q[0];
				output_rate_code_nxt = rate_q[0];
				postfilter_enable_nxt = pfen_q[0];
				postfilter_select_nxt = pfsel_q[0];
				direct_decimation_map_nxt = map_q[0];
				decimation_value_nxt = dec_q[0];
				zero_scale_coeff_nxt = zero_q[0]; // [R05]
				full_scale_coeff_nxt = full_q[0]; // [R08]
			end
		endcase
	end

	// ****************************************
	// read port, restart, setup selection
	// ****************************************
	always @(posedge sys_clk) begin
		if (reset) begin
			reg_rdata_r <= 24'h000000;
			reg_rvalid_r <= 1'b0;
			reg_hit_r <= 1'b0;
			conv_restart_r <= 1'b0;
			filter_order_sel_r <= `AFC_ORD_SINC5;
			output_rate_code_r <= 5'h00;
			postfilter_enable_r <= 1'b0;
			postfilter_select_r <= 3'h0;
			direct_decimation_map_r <= 1'b0;
			decimation_value_r <= 15'h0000;
			zero_scale_coeff_r <= `AFC_ZERO_RST;
			full_scale_coeff_r <= 24'h000000;
		end else begin
			reg_rvalid_r <= reg_rd;
			reg_hit_r <= is_filt | is_zero | is_full;
			if (reg_rd) begin
				reg_rdata_r <= rdata_nxt;
			end
			conv_restart_r <= |filt_we; // [R10]
			// coefficients follow the setup of the active conversion
			filter_order_sel_r <= filter_order_sel_nxt; // [R01]
			output_rate_code_r <= output_rate_code_nxt; // [R02]
			postfilter_enable_r <= postfilter_enable_nxt; // [R11]
			postfilter_select_r <= postfilter_select_nxt;
			direct_decimation_map_r <= direct_decimation_map_nxt; // [R12]
			decimation_value_r <= decimation_value_nxt; // [R12]
			zero_scale_coeff_r <= zero_scale_coeff_nxt; // [R05]
			full_scale_coeff_r <= full_scale_coeff_nxt; // [R08]
		end
	end
endmodule // afc_regs

`default_nettype wire

//--- hdl/afc_consts.vh
`ifndef AFC_CONSTS_VH
`define AFC_CONSTS_VH

// ****************************************
// register addresses
// ****************************************
`define AFC_ADDR_FILT0 6'h28
`define AFC_ADDR_FILT1 6'h29
`define AFC_ADDR_FILT2 6'h2a
`define AFC_ADDR_FILT3 6'h2b
`define AFC_ADDR_ZERO0 6'h30
`define AFC_ADDR_ZERO1 6'h31
`define AFC_ADDR_ZERO2 6'h32
`define AFC_ADDR_ZERO3 6'h33
`define AFC_ADDR_FULL0 6'h38
`define AFC_ADDR_FULL1 6'h39
`define AFC_ADDR_FULL2 6'h3a
`define AFC_ADDR_FULL3 6'h3b

// ****************************************
// reset values
// ****************************************
`define AFC_FILT_RST 16'h0500
`define AFC_ZERO_RST 24'h800000
`define AFC_FULL_TOP 4'h5
`define AFC_FULL_BOT 4'h0
`define AFC_PFSEL_RST 3'h5
`define AFC_DEC_RST 15'h0500

// ****************************************
// filter word fields
// ****************************************
`define AFC_MAP_BIT 15
`define AFC_RSV_HI 14
`define AFC_RSV_LO 12
`define AFC_PFEN_BIT 11
`define AFC_PFSEL_HI 10
`define AFC_PFSEL_LO 8
`define AFC_RSV7_BIT 7
`define AFC_ORD_HI 6
`define AFC_ORD_LO 5
`define AFC_RATE_HI 4
`define AFC_RATE_LO 0
`define AFC_DEC_HI 14
`define AFC_DEC_LO 0
`define AFC_ORD_SINC5 2'h0
`define AFC_ORD_SINC3 2'h3
`define AFC_DEC_MULT 6'h20
`define AFC_FILT_WMASK 16'h8f7f

`endif

//--- hdl/afc_setup_slot.v
`timescale 1ns/1ns
`default_nettype none
`include "afc_consts.vh"

// ****************************************
// one setup: filter word, two coefficients
// ****************************************
module afc_setup_slot #(
	parameter [15:0] FULL_MID = 16'h0000
) (
	input wire sys_clk,
	input wire reset,
	input wire filt_we,
	input wire zero_we,
	input wire full_we,
	input wire [23:0] wr_data,
	output reg [15:0] filt_r,
	output reg [23:0] zero_r,
	output reg [23:0] full_r,
	output reg [1:0] eff_order_r,
	output reg [4:0] eff_rate_r,
	output reg eff_pf_en_r,
	output reg [2:0] eff_pf_sel_r,
	output reg eff_map_r,
	output reg [14:0] eff_dec_r
);
	reg [1:0] ord_nxt;
	reg [15:0] filt_nxt;

	// reserved codes fall back to sinc5+sinc1
	always @* begin
		// direct mapping keeps all fifteen decimation bits
		filt_nxt = wr_data[`AFC_MAP_BIT] ? wr_data[15:0] :
			(wr_data[15:0] & `AFC_FILT_WMASK); // [R12]
		ord_nxt = wr_data[`AFC_ORD_HI:`AFC_ORD_LO]; // [R01]
		if (ord_nxt != `AFC_ORD_SINC3) begin
			ord_nxt = `AFC_ORD_SINC5; // [R13]
		end
	end

	always @(posedge sys_clk) begin
		if (reset) begin
			filt_r <= `AFC_FILT_RST; // [R03]
			zero_r <= `AFC_ZERO_RST; // [R04] [R06]
			full_r <= {`AFC_FULL_TOP, FULL_MID, `AFC_FULL_BOT}; // [R07]
			eff_order_r <= `AFC_ORD_SINC5;
			eff_rate_r <= 5'h00;
			eff_pf_en_r <= 1'b0;
			eff_pf_sel_r <= `AFC_PFSEL_RST;
			eff_map_r <= 1'b0;
			eff_dec_r <= `AFC_DEC_RST;
		end else begin
			if (filt_we) begin
				filt_r <= filt_nxt;
				eff_map_r <= wr_data[`AFC_MAP_BIT];
				eff_dec_r <= filt_nxt[`AFC_DEC_HI:`AFC_DEC_LO]; // [R12]
				// direct mapping forces sinc3, rate code 0 and postfilter off; postfilter select is still stored
				eff_order_r <= wr_data[`AFC_MAP_BIT] ? `AFC_ORD_SINC3 : ord_nxt; // [R12]
				eff_rate_r <= wr_data[`AFC_MAP_BIT] ? 5'h00 :
					wr_data[`AFC_RATE_HI:`AFC_RATE_LO]; // [R02]
				// postfilter only works with sinc5+sinc1
				eff_pf_en_r <= wr_data[`AFC_PFEN_BIT] & ~wr_data[`AFC_MAP_BIT]
					& (ord_nxt == `AFC_ORD_SINC5); // [R11]
				eff_pf_sel_r <= wr_data[`AFC_PFSEL_HI:`AFC_PFSEL_LO];
			end
			if (zero_we) begin
				zero_r <= wr_data; // [R05]
			end
			if (full_we) begin
				full_r <= wr_data;
			end
		end
	end
endmodule // afc_setup_slot

`default_nettype wire

//--- bench/afc_regs_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ***
// bank properties
// ***
module afc_regs_props (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [5:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	input wire logic [23:0] reg_rdata_r,
	input wire logic reg_rvalid_r,
	input wire logic conv_restart_r,
	input wire logic [1:0] filter_order_sel_r,
	input wire logic [4:0] output_rate_code_r,
	input wire logic postfilter_enable_r,
	input wire logic direct_decimation_map_r
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire f_w = reg_addr[5:2] == 4'ha;
	wire m_w = f_w || reg_addr[5:2] == 4'hc || reg_addr[5:2] == 4'he;
	a_rd_answer: assert property (reg_rd |=> reg_rvalid_r) else $error("no rvalid");
	a_unmapped_zero: assert property (reg_rd && !m_w |=> reg_rdata_r == 24'h0)
		else $error("unmapped data");
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_r)) else $error("rdata moved");
	a_restart_write: assert property (reg_wr && f_w |=> conv_restart_r) else $error("no restart");
	a_restart_cause: assert property (conv_restart_r |-> $past(reg_wr && f_w))
		else $error("stray restart");
	a_order_legal: assert property (filter_order_sel_r inside {2'h0, 2'h3}) else $error("order");
	a_map_override: assert property (direct_decimation_map_r |-> filter_order_sel_r == 2'h3
		&& output_rate_code_r == 5'h0 && !postfilter_enable_r) else $error("map");
	a_zero_wr_rd: assert property (reg_wr && reg_addr == 6'h30 ##1 !reg_wr ##1 reg_rd
		&& !reg_wr && reg_addr == 6'h30 |=> reg_rdata_r == $past(reg_wdata, 3)) else $error("zero lost");
endmodule // afc_regs_props
bind afc_regs afc_regs_props afc_regs_props_i (.sys_clk, .reset, .reg_wr, .reg_rd, .reg_addr,
	.reg_wdata, .reg_rdata_r, .reg_rvalid_r, .conv_restart_r, .filter_order_sel_r,
	.output_rate_code_r, .postfilter_enable_r, .direct_decimation_map_r);
`default_nettype wire

//--- bench/tb_afc_regs.sv
`timescale 1ns/1ns
`default_nettype none
// ***
// bank bench
// ***
module tb_afc_regs;
	logic sys_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0;
	logic [5:0] reg_addr = 0, a;
	logic [23:0] reg_wdata = 0, d, m [0:63];
	logic [1:0] conv_setup = 0;
	wire [23:0] rdat, zs, fs;
	wire [14:0] dec;
	wire [4:0] rate;
	wire [1:0] ord;
	wire rv, rp, hr, pe, mp;
	wire [2:0] ps;
	int n_mismatch = 0, comparisons = 0, cyc = 0;
	always #10 sys_clk = ~sys_clk;
	afc_regs afc_regs_i (.sys_clk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .conv_setup,
		.reg_rdata_r(rdat), .reg_rvalid_r(rv), .reg_hit_r(hr), .conv_restart_r(rp),
		.filter_order_sel_r(ord), .output_rate_code_r(rate), .postfilter_enable_r(pe),
		.postfilter_select_r(ps), .direct_decimation_map_r(mp), .decimation_value_r(dec),
		.zero_scale_coeff_r(zs), .full_scale_coeff_r(fs));
	function automatic logic hit(logic [5:0] x);
		return x[5:2] == 4'ha || x[5:2] == 4'hc || x[5:2] == 4'he;
	endfunction
	// stored filter word: direct mapping keeps all decimation bits
	function automatic logic [23:0] fw(logic [23:0] v);
		return v[15] ? {8'h0, v[15:0]} : {8'h0, v[15:0] & 16'h8f7f};
	endfunction
	task automatic chk(string s, logic [23:0] e, logic [23:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask
	// drive on a rising edge, strobe taken at the next, answer checked mid-cycle
	task automatic acc(logic w, logic r, logic [5:0] x, logic [23:0] v);
		@(posedge sys_clk);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= x;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 0;
		reg_rd <= 0;
		@(negedge sys_clk);
	endtask
	task automatic rd(logic [5:0] x);
		acc(0, 1, x, 0);
		chk("rvalid", 1, rv);
		chk("rdata", m[x], rdat);
		chk("hit", hit(x), hr);
	endtask
	task automatic wr(logic [5:0] x, logic [23:0] v);
		acc(1, 0, x, v);
		if (hit(x)) m[x] = x[5:2] == 4'ha ? fw(v) : v;
		chk("restart", x[5:2] == 4'ha, rp);
		chk("rvalid", 0, rv);
		chk("hit", hit(x), hr);
	endtask
	initial begin
		void'($urandom(32'hb3a979a0));
		for (int i = 0; i < 64; i++) begin
			m[i] = !hit(6'(i)) ? 24'h0 : i < 48 ? 24'h500 : i < 56 ? 24'h800000 : 24'h500000;
		end
		repeat (4) @(posedge sys_clk);
		reset <= 0;
		for (int i = 40; i < 60; i++) rd(6'(i));
		for (int i = 0; i < 40; i++) begin
			a = i == 0 ? 6'h30 : i == 1 ? 6'h29 : 6'h28 + 6'($urandom % 20);
			d = i == 1 ? 24'hffffff : 24'($urandom);
			wr(a, d);
			rd(a);
		end
		wr(6'h28, 24'h000a25);
		rd(6'h28);
		wr(6'h2a, 24'h000d05);
		wr(6'h2b, 24'h00c841);
		rd(6'h2b);
		for (int s = 0; s < 4; s++) begin
			@(posedge sys_clk);
			conv_setup <= 2'(s);
			acc(0, 0, 0, 0);
			d = m[40 + s];
			chk("zero", m[48 + s], zs);
			chk("full", m[56 + s], fs);
			chk("order", d[15] || d[6:5] == 2'h3 ? 2'h3 : 2'h0, ord);
			chk("rate", d[15] ? 5'h0 : d[4:0], rate);
			chk("dec", d[14:0], dec);
			chk("map", d[15], mp);
			chk("pfen", d[11] && !d[15] && d[6:5] != 2'h3, pe);
			chk("pfsel", d[10:8], ps);
		end
		tally_and_finish;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_mismatch++;
			tally_and_finish;
		end
	end
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
endmodule // tb_afc_regs
`default_nettype wire
